//--- verilog/ltoc_pkg.sv
/*
  Shared constants for the panel timing and overdrive controller.
  Assumes a 50 MHz system clock and a link pixel clock sampled as data.
*/
package ltoc_pkg;
  // ------------------------------------------------------------
  // Link and pixel format
  // ------------------------------------------------------------
  localparam int LINK_LANES = 4;
  localparam int LANE_BITS = 7;
  localparam int PIX_BITS = 24;
  localparam int COLOR_BITS = 8;
  localparam int CH_R_LSB = 16;
  localparam int CH_G_LSB = 8;
  localparam int CH_B_LSB = 0;
  // ------------------------------------------------------------
  // Clock figures
  // ------------------------------------------------------------
  localparam int SYS_CLK_HZ = 50000000;
  localparam int LINK_MIN_KHZ = 30000;
  localparam int LINK_MAX_KHZ = 95000;
  localparam int COL_CLK_MAX_KHZ = 47500;
  localparam int COL_CLK_DIV = (SYS_CLK_HZ / 1000 + COL_CLK_MAX_KHZ - 1) / COL_CLK_MAX_KHZ;
  // ------------------------------------------------------------
  // Overdrive table
  // ------------------------------------------------------------
  localparam int LUT_IDX_BITS = 4;
  localparam int LUT_ENTRIES = 256;
  localparam int ROM_STEP = 16;
  localparam int EEPROM_WAIT = 1024;
  // ------------------------------------------------------------
  // Output buses and timing
  // ------------------------------------------------------------
  localparam int PAIRS_8B = 13;
  localparam int PAIRS_6B = 10;
  localparam int DATA_PAIRS = 12;
  localparam int SKEW_BITS = 3;
  localparam int SKEW_STEPS = 8;
  localparam logic [1:0] FMT_1024X768 = 2'h0;
  localparam logic [1:0] FMT_1280X768 = 2'h1;
  localparam logic [1:0] FMT_1366X768 = 2'h2;
  localparam logic [1:0] FMT_1280X800 = 2'h3;
  localparam int ROW_START_W = 4;
  localparam int ROW_CLK_W = 16;
  typedef enum logic [1:0] {
    LTOC_LOAD_WAIT = 2'b00,
    LTOC_LOAD_EEP = 2'b01,
    LTOC_LOAD_ROM = 2'b11,
    LTOC_LOAD_DONE = 2'b10
  } ltoc_load_t;
endpackage

//--- verilog/ltoc_sync2.sv
/*
  Two flip-flop synchroniser for one level.
  Assumes the input is asynchronous to clk_sys.
*/
`timescale 1ns/100ps
module ltoc_sync2 (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_q;
  // Only the second stage is visible outside
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

//--- verilog/ltoc_buf2.sv
/*
  Two-entry valid/ready buffer.
  Assumes source and sink on clk_sys.
*/
`timescale 1ns/100ps
module ltoc_buf2 #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Pointers wrap at DEPTH
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
  // Storage carries no reset
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

//--- verilog/ltoc_top.sv
/*
  Panel timing controller datapath with overdrive, dithering and skew.
  Assumes the deserialised link lanes, the link clock, the frame memory
  read data and the EEPROM answer are all asynchronous and are sampled.
*/
`timescale 1ns/100ps
module ltoc_top import ltoc_pkg::*; #(
  parameter int EEP_WAIT = EEPROM_WAIT,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pixel_clock_in,
  input wire logic [LINK_LANES*LANE_BITS-1:0] link_lanes,
  input wire logic spread_spectrum_clock_input,
  input wire logic spread_enable,
  input wire logic eeprom_ack,
  input wire logic [COLOR_BITS-1:0] eeprom_data,
  input wire logic eeprom_data_valid,
  input wire logic [PIX_BITS-1:0] fmem_rd_data,
  input wire logic [SKEW_BITS-1:0] output_skew_select,
  input wire logic six_bit_mode,
  input wire logic top_mount,
  input wire logic overdrive_enable,
  input wire logic [1:0] panel_format,
  output logic [PIX_BITS-1:0] fmem_wr_data,
  output logic fmem_wr_en,
  output logic fmem_rd_en,
  output logic eeprom_req,
  output logic column_driver_clock_pair,
  output logic [2*DATA_PAIRS-1:0] column_driver_color_pairs,
  output logic column_load,
  output logic row_start,
  output logic row_clock,
  output logic table_ready
);
  // ------------------------------------------------------------
  // Input sampling
  // ------------------------------------------------------------
  logic pclk_s;
  logic sscin_s;
  logic eack_s;
  logic evld_s;
  logic [LINK_LANES*LANE_BITS-1:0] lane_m_q;
  logic [LINK_LANES*LANE_BITS-1:0] lane_s_q;
  logic [PIX_BITS-1:0] fm_m_q;
  logic [PIX_BITS-1:0] fm_s_q;
  logic [COLOR_BITS-1:0] ed_m_q;
  logic [COLOR_BITS-1:0] ed_s_q;
  ltoc_sync2 u_sync_pclk (.clk_sys(clk_sys), .rst_n(rst_n), .d(pixel_clock_in), .q(pclk_s));
  ltoc_sync2 u_sync_ssc (.clk_sys(clk_sys), .rst_n(rst_n),
    .d(spread_spectrum_clock_input), .q(sscin_s));
  ltoc_sync2 u_sync_eack (.clk_sys(clk_sys), .rst_n(rst_n), .d(eeprom_ack), .q(eack_s));
  ltoc_sync2 u_sync_evld (.clk_sys(clk_sys), .rst_n(rst_n), .d(eeprom_data_valid),
    .q(evld_s));
  // Buses pass two stages too; they are only read on a stable link edge or, for EEPROM data, on EEPROM data valid
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lane_m_q <= '0;
      lane_s_q <= '0;
      fm_m_q <= '0;
      fm_s_q <= '0;
      ed_m_q <= '0;
      ed_s_q <= '0;
    end else begin
      lane_m_q <= link_lanes;
      lane_s_q <= lane_m_q;
      fm_m_q <= fmem_rd_data;
      fm_s_q <= fm_m_q;
      ed_m_q <= eeprom_data;
      ed_s_q <= ed_m_q;
    end
  end
  // ------------------------------------------------------------
  // Link clock edge and pixel unpack
  // ------------------------------------------------------------
  logic pclk_d_q;
  logic pix_stb;
  logic [PIX_BITS-1:0] in_pix;
  logic in_de;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pclk_d_q <= 1'b0;
    end else begin
      pclk_d_q <= pclk_s;
    end
  end
  // Sampling a 95 MHz link at 50 MHz is lossy; the bench runs it slower
  assign pix_stb = pclk_s && !pclk_d_q;
  // Lanes 0..3 carry 6+6+6+6 colour bits, lane 3 also DE
  assign in_pix = {lane_s_q[5:0], lane_s_q[12:7], lane_s_q[19:14], lane_s_q[26:21]};
  assign in_de = lane_s_q[27];
  // ------------------------------------------------------------
  // Overdrive table load
  // ------------------------------------------------------------
  ltoc_load_t ld_q;
  logic [7:0] lut_q [LUT_ENTRIES];
  logic [$clog2(LUT_ENTRIES):0] ld_idx_q;
  logic [$clog2(EEP_WAIT+1)-1:0] ld_wait_q;
  logic rdy_q;
  logic eeq_q;
  // Load sequence runs straight out of reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ld_q <= LTOC_LOAD_WAIT;
      ld_idx_q <= '0;
      ld_wait_q <= '0;
      rdy_q <= 1'b0;
      eeq_q <= 1'b0;
    end else begin
      case (ld_q)
        LTOC_LOAD_WAIT: begin
          eeq_q <= 1'b1;
          ld_wait_q <= ld_wait_q + 1'b1;
          if (eack_s) begin
            ld_q <= LTOC_LOAD_EEP;
          end else if (ld_wait_q == ($clog2(EEP_WAIT+1))'(EEP_WAIT)) begin
            ld_q <= LTOC_LOAD_ROM;
            eeq_q <= 1'b0;
          end
        end
        LTOC_LOAD_EEP: begin
          if (evld_s) begin
            ld_idx_q <= ld_idx_q + 1'b1;
          end
          if (ld_idx_q == ($clog2(LUT_ENTRIES)+1)'(LUT_ENTRIES)) begin
            ld_q <= LTOC_LOAD_DONE;
            eeq_q <= 1'b0;
          end
        end
        LTOC_LOAD_ROM: begin
          ld_idx_q <= ld_idx_q + 1'b1;
          if (ld_idx_q == ($clog2(LUT_ENTRIES)+1)'(LUT_ENTRIES - 1)) begin
            ld_q <= LTOC_LOAD_DONE;
          end
        end
        LTOC_LOAD_DONE: begin
          rdy_q <= 1'b1;
        end
        default: begin
          ld_q <= LTOC_LOAD_WAIT;
        end
      endcase
    end
  end
  // Table writes; ROM entry overshoots target by half of the step
  logic [3:0] rom_cur;
  logic [3:0] rom_prv;
  logic [7:0] rom_val;
  assign rom_cur = ld_idx_q[7:4];
  assign rom_prv = ld_idx_q[3:0];
  always_comb begin
    rom_val = {rom_cur, 4'h0};
    if (rom_cur > rom_prv && rom_cur != 4'hF) begin
      rom_val = {rom_cur, 4'h0} + 8'h08;
    end else if (rom_cur < rom_prv && rom_cur != 4'h0) begin
      rom_val = {rom_cur, 4'h0} - 8'h08;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (ld_q == LTOC_LOAD_ROM) begin
      lut_q[ld_idx_q[7:0]] <= rom_val;
    end else if (ld_q == LTOC_LOAD_EEP && evld_s && !ld_idx_q[8]) begin
      lut_q[ld_idx_q[7:0]] <= ed_s_q;
    end
  end
  // ------------------------------------------------------------
  // Frame memory and first-frame guard
  // ------------------------------------------------------------
  logic de_d_q;
  logic prev_ok_q;
  logic [11:0] blank_q;
  // A long DE-low gap marks vertical blanking
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      de_d_q <= 1'b0;
      blank_q <= '0;
      prev_ok_q <= 1'b0;
    end else if (pix_stb) begin
      de_d_q <= in_de;
      if (in_de) begin
        blank_q <= '0;
        if (blank_q == 12'hFFF) begin
          prev_ok_q <= 1'b1;
        end
      end else if (blank_q != 12'hFFF) begin
        blank_q <= blank_q + 1'b1;
      end
    end
  end
  // Write current, read previous for the same pixel
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fmem_wr_data <= '0;
      fmem_wr_en <= 1'b0;
      fmem_rd_en <= 1'b0;
      eeprom_req <= 1'b0;
      table_ready <= 1'b0;
    end else begin
      fmem_wr_en <= pix_stb && in_de;
      fmem_rd_en <= pix_stb && in_de;
      fmem_wr_data <= in_pix;
      eeprom_req <= eeq_q;
      table_ready <= rdy_q;
    end
  end
  // ------------------------------------------------------------
  // Overdrive and dither
  // ------------------------------------------------------------
  logic [PIX_BITS-1:0] od_pix;
  logic [1:0] frc_phase_q;
  always_comb begin
    od_pix = in_pix;
    for (int c = 0; c < 3; c++) begin
      if (rdy_q && prev_ok_q && overdrive_enable) begin
        od_pix[c*8 +: 8] = lut_q[{in_pix[c*8+4 +: 4], fm_s_q[c*8+4 +: 4]}];
      end
    end
  end
  // Two-bit frame-rate control phase steps per frame
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frc_phase_q <= '0;
    end else if (pix_stb && in_de && !de_d_q && blank_q == 12'hFFF) begin
      frc_phase_q <= frc_phase_q + 1'b1;
    end
  end
  logic [PIX_BITS-1:0] frc_pix;
  always_comb begin
    frc_pix = od_pix;
    for (int c = 0; c < 3; c++) begin
      if (six_bit_mode && od_pix[c*8 +: 2] > frc_phase_q && od_pix[c*8+2 +: 6] != 6'h3F) begin
        frc_pix[c*8 +: 8] = {od_pix[c*8+2 +: 6] + 6'h01, 2'h0};
      end else if (six_bit_mode) begin
        frc_pix[c*8 +: 8] = {od_pix[c*8+2 +: 6], 2'h0};
      end
    end
  end
  // ------------------------------------------------------------
  // Output buffer and column clock
  // ------------------------------------------------------------
  logic b_ready;
  logic b_valid;
  logic [PIX_BITS:0] b_data;
  logic col_tick;
  logic [3:0] div_q;
  logic sel_clk;
  logic sel_d_q;
  // Spread clock, when enabled, paces the column tick and every output it drives
  assign sel_clk = spread_enable ? sscin_s : pclk_s;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_d_q <= 1'b0;
      div_q <= '0;
    end else begin
      sel_d_q <= sel_clk;
      div_q <= (div_q == 4'(COL_CLK_DIV - 1)) ? '0 : div_q + 1'b1;
    end
  end
  // Column tick never faster than system clock / COL_CLK_DIV
  // A tick only moves a waiting pixel, so idle ticks never fake a DE gap
  assign col_tick = b_valid && (div_q == '0) && (spread_enable ? (sel_clk && !sel_d_q) : 1'b1);
  ltoc_buf2 #(.WIDTH(PIX_BITS + 1), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(pix_stb && b_ready),
    .in_ready(b_ready),
    .in_data({in_de, frc_pix}),
    .out_valid(b_valid),
    .out_ready(col_tick),
    .out_data(b_data)
  );
  // ------------------------------------------------------------
  // Aligned delay line, skew and timing generator
  // ------------------------------------------------------------
  logic [PIX_BITS:0] dl_q [SKEW_STEPS];
  logic ck_q;
  logic [ROW_CLK_W-1:0] hcnt_q;
  logic [ROW_CLK_W-1:0] hact;
  always_comb begin
    case (panel_format)
      FMT_1024X768: hact = 16'h0400;
      FMT_1280X768: hact = 16'h0500;
      FMT_1366X768: hact = 16'h0556;
      FMT_1280X800: hact = 16'h0500;
      default: hact = 16'h0400;
    endcase
  end
  // Data and DE share one delay line so they stay aligned
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SKEW_STEPS; i++) begin
        dl_q[i] <= '0;
      end
    end else if (col_tick) begin
      dl_q[0] <= b_valid ? b_data : '0;
      for (int i = 1; i < SKEW_STEPS; i++) begin
        dl_q[i] <= dl_q[i-1];
      end
    end
  end
  // Timing signals and clock are fixed; only data taps move
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ck_q <= 1'b0;
      column_driver_clock_pair <= 1'b0;
      column_driver_color_pairs <= '0;
      column_load <= 1'b0;
      row_start <= 1'b0;
      row_clock <= 1'b0;
      hcnt_q <= '0;
    end else begin
      column_driver_clock_pair <= col_tick;
      // Timing strobes last one cycle; a tick below may raise them again
      column_load <= 1'b0;
      row_start <= 1'b0;
      row_clock <= 1'b0;
      if (col_tick) begin
        // Tap chosen by skew select shifts data against clock
        if (top_mount) begin
          column_driver_color_pairs <= {<<{dl_q[output_skew_select][PIX_BITS-1:0]}};
        end else begin
          column_driver_color_pairs <= dl_q[output_skew_select][PIX_BITS-1:0];
        end
        column_load <= dl_q[SKEW_STEPS-1][PIX_BITS] == 1'b0 && ck_q;
        ck_q <= dl_q[SKEW_STEPS-1][PIX_BITS];
        row_clock <= dl_q[SKEW_STEPS-1][PIX_BITS] && !ck_q;
        row_start <= dl_q[SKEW_STEPS-1][PIX_BITS] && !ck_q && hcnt_q == '0;
        if (dl_q[SKEW_STEPS-1][PIX_BITS]) begin
          hcnt_q <= (hcnt_q == hact - 1'b1) ? hcnt_q : hcnt_q + 1'b1;
        end else begin
          hcnt_q <= '0;
        end
      end
    end
  end
endmodule

//--- verif/ltoc_top_properties.sv
/*
  Port checker for ltoc_top, bound into every instance.
  Assumes one clk_sys domain with async active-low rst_n.
*/
`timescale 1ns/100ps
module ltoc_top_chk import ltoc_pkg::*; #(
  parameter int EEP_WAIT = EEPROM_WAIT,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fmem_wr_en,
  input wire logic fmem_rd_en,
  input wire logic eeprom_req,
  input wire logic column_driver_clock_pair,
  input wire logic [2*DATA_PAIRS-1:0] column_driver_color_pairs,
  input wire logic column_load,
  input wire logic row_clock,
  input wire logic table_ready
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  reset_quiet_a: assert property ($rose(rst_n) |-> !table_ready && !eeprom_req)
    else $error("outputs busy right after reset");
  tbl_load_bound_a: assert property ($rose(rst_n) |-> ##[1:1000] table_ready)
    else $error("table never became ready");
  ready_sticky_a: assert property (table_ready |=> table_ready)
    else $error("table ready dropped");
  req_off_a: assert property (table_ready |-> !eeprom_req)
    else $error("table load request while ready");
  col_clk_rate_a: assert property (
    column_driver_clock_pair |=> !column_driver_clock_pair)
    else $error("column clock too fast");
  pairs_hold_a: assert property (!$stable(column_driver_color_pairs) |=>
    $stable(column_driver_color_pairs))
    else $error("colour pairs changed between ticks");
  // Link period is at least four cycles, so writes are spaced
  wr_space_a: assert property (fmem_wr_en |=> !fmem_wr_en [*3])
    else $error("frame writes too close");
  rd_pulse_a: assert property (fmem_rd_en |=> !fmem_rd_en)
    else $error("frame read held");
  ctl_pulse_a: assert property (
    row_clock || column_load |=> !row_clock && !column_load)
    else $error("timing pulse off the column tick");
  cover property ($rose(table_ready));
  cover property (fmem_wr_en && fmem_rd_en);
  cover property (column_load);
endmodule

bind ltoc_top ltoc_top_chk #(.EEP_WAIT(EEP_WAIT), .BUF_DEPTH(BUF_DEPTH)) u_chk (
  .clk_sys, .rst_n, .fmem_wr_en, .fmem_rd_en, .eeprom_req, .column_driver_clock_pair,
  .column_driver_color_pairs, .column_load, .row_clock, .table_ready
);

//--- verif/ltoc_host_model.sv
/*
  Host side of the pixel link: sends pixels with a data enable.
  Assumes the caller spaces calls; the link clock idles low between them.
*/
`timescale 1ns/100ps
module ltoc_host_model import ltoc_pkg::*; (
  output logic pixel_clock_in,
  output logic [LINK_LANES*LANE_BITS-1:0] link_lanes
);
  initial begin
    pixel_clock_in = 1'b0;
    link_lanes = '0;
  end
  // Data set while the clock is low, 160 ns per pixel
  task automatic send(input logic [PIX_BITS-1:0] pix, input logic de, input int n);
    for (int i = 0; i < n; i++) begin
      link_lanes = {de, pix[5:0], 1'b0, pix[11:6], 1'b0, pix[17:12], 1'b0, pix[23:18]};
      #80 pixel_clock_in = 1'b1;
      #80 pixel_clock_in = 1'b0;
    end
    // Released lanes must not look like a held pixel
    link_lanes = ~link_lanes;
  endtask
endmodule

//--- verif/lcd_timing_overdrive_controller_tb_top.sv
/*
  Self-checking bench for ltoc_top with link host and frame memory.
  Assumes the checker is bound and EEP_WAIT is shortened to 16.
*/
`timescale 1ns/100ps
module lcd_timing_overdrive_controller_tb_top import ltoc_pkg::*;;
  localparam int EW = 16;
  localparam logic [23:0] PA = 24'h2AC460;
  localparam logic [23:0] PB = 24'hD138F0;
  localparam logic [23:0] PC = 24'h5CA034;
  logic clk_sys, rst_n, pixel_clock_in, spread_spectrum_clock_input, spread_enable;
  logic eeprom_ack, eeprom_data_valid, six_bit_mode, top_mount, overdrive_enable;
  logic fmem_wr_en, fmem_rd_en, eeprom_req, column_driver_clock_pair;
  logic column_load, row_start, row_clock, table_ready;
  logic [LINK_LANES*LANE_BITS-1:0] link_lanes;
  logic [7:0] eeprom_data;
  logic [23:0] fmem_rd_data, fmem_wr_data, column_driver_color_pairs;
  logic [2:0] output_skew_select;
  logic [1:0] panel_format;
  logic [23:0] fmem_q[$];
  int fail_count, checked, frame_len;
  // ----
  // Instances
  // ----
  ltoc_top #(.EEP_WAIT(EW), .BUF_DEPTH(2)) u_dut (.clk_sys, .rst_n, .pixel_clock_in,
    .link_lanes, .spread_spectrum_clock_input, .spread_enable, .eeprom_ack, .eeprom_data,
    .eeprom_data_valid, .fmem_rd_data, .output_skew_select, .six_bit_mode, .top_mount,
    .overdrive_enable, .panel_format, .fmem_wr_data, .fmem_wr_en, .fmem_rd_en, .eeprom_req,
    .column_driver_clock_pair, .column_driver_color_pairs, .column_load, .row_start,
    .row_clock, .table_ready);
  ltoc_host_model u_host (.pixel_clock_in, .link_lanes);
  // Clocks; the spread clock runs free and paces the output only when enabled
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    spread_spectrum_clock_input = 1'b0;
    forever #23 spread_spectrum_clock_input = ~spread_spectrum_clock_input;
  end
  // Frame memory: hands back a pixel only once a full frame is stored
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fmem_q.delete();
    end else begin
      if (fmem_rd_en) fmem_rd_data <= #2 (fmem_q.size() >= frame_len) ? fmem_q.pop_front()
        : ~fmem_rd_data;
      if (fmem_wr_en) fmem_q.push_back(fmem_wr_data);
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic ack);
    rst_n = 1'b0;
    eeprom_ack = ack;
    repeat (10) @(posedge clk_sys);
    #2 rst_n = 1'b1;
  endtask
  task automatic wait_ready(output int n, output logic saw_req);
    n = 0;
    saw_req = 1'b0;
    while (table_ready !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      #2 n++;
      saw_req |= (eeprom_req === 1'b1);
    end
  endtask
  // Checks the pairs mid-stream, while fresh pixels keep arriving
  task automatic send_check(input string what, input logic [23:0] pix, input logic [23:0] exp);
    fork
      u_host.send(pix, 1'b1, 24);
      begin
        repeat (160) @(posedge clk_sys);
        #2 cmp(what, exp, column_driver_color_pairs);
      end
    join
  endtask
  // ----
  // Scenarios
  // ----
  task automatic test_rom_first_frame();
    int n;
    logic req;
    logic [23:0] rev;
    do_reset(1'b0);
    wait_ready(n, req);
    cmp("load request", 1, req);
    cmp("rom fill not early", 1, n >= EW + 255);
    cmp("rom fill not late", 1, n <= EW + 265);
    overdrive_enable = 1'b1;
    send_check("first frame pass", PA, PA);
    cmp("frame writes", 24, fmem_q.size());
    cmp("frame write data", PA, fmem_q[$]);
    top_mount = 1'b1;
    rev = {<<{PA}};
    send_check("top mount map", PA, rev);
    top_mount = 1'b0;
    six_bit_mode = 1'b1;
    send_check("six bit plain", PC, PC);
    // No blank gap yet, so the phase is zero: nonzero low bits round up
    send_check("six bit dither", 24'h5DA136, 24'h60A438);
    six_bit_mode = 1'b0;
    spread_enable = 1'b1;
    send_check("spread clock pace", PA, PA);
    spread_enable = 1'b0;
  endtask
  task automatic test_skew();
    int lat[2];
    int loads[2];
    int rows[2];
    int t;
    logic req;
    overdrive_enable = 1'b0;
    panel_format = FMT_1366X768;
    for (int k = 0; k < 2; k++) begin
      do_reset(1'b0);
      wait_ready(t, req);
      output_skew_select = k ? 3'h7 : 3'h0;
      lat[k] = 0;
      loads[k] = 0;
      rows[k] = 0;
      fork
        begin
          u_host.send(PA, 1'b1, 8);
          u_host.send(PB, 1'b1, 24);
        end
        begin
          t = 0;
          while (!(fmem_wr_en === 1'b1 && fmem_wr_data === PB) && t < 200) begin
            @(posedge clk_sys);
            #2 t++;
          end
          for (t = 0; t < 150; t++) begin
            @(posedge clk_sys);
            #2 loads[k] += (column_load === 1'b1);
            rows[k] += (row_start === 1'b1);
            if (column_driver_clock_pair === 1'b1 && column_driver_color_pairs !== PB) lat[k]++;
          end
        end
      join
      cmp("data after skew", PB, column_driver_color_pairs);
      cmp("one row start per line", 1, rows[k]);
    end
    cmp("skew step count", 7, lat[1] - lat[0]);
    cmp("timing unmoved by skew", loads[0], loads[1]);
    cmp("row start unmoved by skew", rows[0], rows[1]);
    output_skew_select = 3'h0;
  endtask
  task automatic test_eeprom_overdrive();
    int n;
    logic req;
    logic [23:0] exp;
    panel_format = FMT_1280X800;
    do_reset(1'b1);
    n = 0;
    while (eeprom_req !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #2 n++;
    end
    // One byte per high cycle, with a gap so each is seen once
    for (int k = 0; k < LUT_ENTRIES; k++) begin
      eeprom_data = 8'(k) ^ 8'h5A;
      eeprom_data_valid = 1'b1;
      @(posedge clk_sys);
      #2 eeprom_data_valid = 1'b0;
      @(posedge clk_sys);
      #2;
    end
    wait_ready(n, req);
    cmp("eeprom table ready", 1, table_ready);
    overdrive_enable = 1'b1;
    u_host.send(PA, 1'b1, 64);
    u_host.send(24'h000000, 1'b0, 4100);
    for (int c = 0; c < 3; c++) exp[8*c +: 8] = {PB[8*c+4 +: 4], PA[8*c+4 +: 4]} ^ 8'h5A;
    send_check("overdrive value", PB, exp);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    fail_count = 0;
    checked = 0;
    frame_len = 64;
    rst_n = 1'b0;
    eeprom_ack = 1'b0;
    eeprom_data = 8'h00;
    eeprom_data_valid = 1'b0;
    fmem_rd_data = 24'h000000;
    output_skew_select = 3'h0;
    six_bit_mode = 1'b0;
    top_mount = 1'b0;
    overdrive_enable = 1'b0;
    panel_format = FMT_1024X768;
    spread_enable = 1'b0;
    test_rom_first_frame();
    $display("test rom_first_frame done");
    test_skew();
    $display("test skew done");
    test_eeprom_overdrive();
    $display("test eeprom_overdrive done");
    report_and_stop();
  end
  // Watchdog: about twice the expected run
  initial begin
    #1400000;
    fail_count++;
    report_and_stop();
  end
endmodule
